// file: core/flash_host_pkg.sv
package flash_host_pkg;
  // ==========================================================
  // register map, byte addresses on apb
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_ADDR   = 8'h04;
  localparam logic [7:0] OFF_WDATA  = 8'h08;
  localparam logic [7:0] OFF_RDATA  = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_CFG    = 8'h14;
  // ==========================================================
  // field positions
  localparam int CTRL_GO      = 0;
  localparam int CTRL_CMD_LSB = 4;
  localparam int ST_BUSY      = 0;
  localparam int ST_DONE      = 1;
  localparam int ST_TIMEOUT   = 2;
  localparam int ST_VERIFY    = 3;
  localparam int ST_AUTOSEL   = 4;
  localparam int ST_REFUSED   = 5;
  localparam int ST_RDY       = 6;
  localparam int ST_SUPPLY    = 7;
  localparam int CFG_BYTE     = 0;
  localparam int CFG_IDV      = 1;
  // ==========================================================
  // commands software may start
  typedef enum logic [2:0] {
    CMD_READ    = 3'h0,
    CMD_RESET   = 3'h1,
    CMD_AUTOSEL = 3'h2,
    CMD_PROGRAM = 3'h3,
    CMD_HWRESET = 3'h4
  } cmd_t;
  localparam logic [15:0] RESET_CODE = 16'h00f0;
  localparam logic [15:0] BYTE_MASK  = 16'h00ff;
  // ==========================================================
  // timing, in ns, and cycle counts at 100 mhz
  localparam int CLK_NS     = 10;
  localparam int T_WE_NS    = 50;   // well above the glitch filter
  localparam int T_WH_NS    = 30;
  localparam int T_RD_NS    = 100;
  localparam int T_RP_NS    = 500;
  localparam int T_RH_NS    = 100;
  localparam int T_BUSY_NS  = 100;
  localparam int C_WE   = (T_WE_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_WH   = (T_WH_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_RD   = (T_RD_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_RP   = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_RH   = (T_RH_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_BUSY = (T_BUSY_NS + CLK_NS - 1) / CLK_NS;
endpackage

// file: core/flash_host.sv
// Notes on behaviour
// - writes only with chip select and strobe low, output enable high.
// - host writes reset code after timeout and to leave autoselect.
// - autoselect entry is two unlocks then the autoselect code.
// - program is two unlocks, setup code, then address and data.
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
module flash_host #(
  parameter int          ADDR_W       = 19,
  parameter int          PROG_TIMEOUT = 100000,
  parameter logic [18:0] UNLOCK1_ADDR = 19'h0_0001,
  parameter logic [18:0] UNLOCK2_ADDR = 19'h0_0002,
  parameter logic [15:0] UNLOCK1_DATA = 16'h0001,
  parameter logic [15:0] UNLOCK2_DATA = 16'h0002,
  parameter logic [15:0] AUTOSEL_CODE = 16'h0003,
  parameter logic [15:0] PROGRAM_CODE = 16'h0004
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // flash pins
  output logic      [ADDR_W-1:0] fl_addr,
  output logic      [15:0]       fl_dq_o,
  input  wire logic [15:0]       fl_dq_i,
  output logic                   fl_dq_oe,
  output logic                   fl_ce_n,
  output logic                   fl_we_n,
  output logic                   fl_oe_n,
  output logic                   fl_reset_n,
  output logic                   fl_byte_n,
  output logic                   id_voltage_en,
  input  wire logic              ready_busy_n,
  input  wire logic              supply_ok
);
  typedef enum logic [3:0] {
    S_IDLE, S_WR_SETUP, S_WR_LOW, S_WR_HIGH, S_PG_WAIT,
    S_RD_SETUP, S_RD_LOW, S_RD_END, S_HW_LOW, S_HW_REC
  } state_t;

  // ==========================================================
  // sequence tables
  function automatic logic [1:0] last_step(input flash_host_pkg::cmd_t c);
    unique case (c)
      flash_host_pkg::CMD_PROGRAM: last_step = 2'd3;
      flash_host_pkg::CMD_AUTOSEL: last_step = 2'd2;
      default:                     last_step = 2'd0;
    endcase
  endfunction

  function automatic logic [ADDR_W+15:0] seq_word(input flash_host_pkg::cmd_t c, input logic [1:0] s,
                                                  input logic [ADDR_W-1:0] a, input logic [15:0] d);
    if (c == flash_host_pkg::CMD_RESET)
      seq_word = {a, flash_host_pkg::RESET_CODE};
    else
    begin
      unique case (s)
        2'd0:    seq_word = {UNLOCK1_ADDR[ADDR_W-1:0], UNLOCK1_DATA};
        2'd1:    seq_word = {UNLOCK2_ADDR[ADDR_W-1:0], UNLOCK2_DATA};
        2'd2:    seq_word = {UNLOCK1_ADDR[ADDR_W-1:0],
                             (c == flash_host_pkg::CMD_PROGRAM) ? PROGRAM_CODE : AUTOSEL_CODE};
        default: seq_word = {a, d};
      endcase
    end
  endfunction

  // ==========================================================
  // pin synchronisers
  logic [2:0]  rb_s_q, sup_s_q;
  logic        rb_f_q, sup_f_q;
  logic [15:0] dq1_q, dq2_q, dq3_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rb_s_q  <= 3'b000;
      sup_s_q <= 3'b000;
      rb_f_q  <= 1'b0;
      sup_f_q <= 1'b0;
      dq1_q   <= 16'h0000;
      dq2_q   <= 16'h0000;
      dq3_q   <= 16'h0000;
    end
    else
    begin
      rb_s_q  <= {rb_s_q[1:0], ready_busy_n};
      sup_s_q <= {sup_s_q[1:0], supply_ok};
      if (rb_s_q[1] == rb_s_q[2])
        rb_f_q <= rb_s_q[2];
      if (sup_s_q[1] == sup_s_q[2])
        sup_f_q <= sup_s_q[2];
      dq1_q <= fl_dq_i;
      dq2_q <= dq1_q;
      dq3_q <= dq2_q;
    end
  end

  // ==========================================================
  // registers and sequencer
  state_t                state_q, state_d;
  flash_host_pkg::cmd_t  cmd_q, cmd_d;
  logic [1:0]            step_q, step_d;
  logic [31:0]           cnt_q, cnt_d;
  logic [ADDR_W-1:0]     areg_q, areg_d, fa_q, fa_d;
  logic [15:0]           wreg_q, wreg_d, rreg_q, rreg_d, dqo_q, dqo_d;
  logic [1:0]            cfg_q, cfg_d;
  logic                  done_q, done_d, tmo_q, tmo_d, ver_q, ver_d, asel_q, asel_d, ref_q, ref_d;
  logic                  verify_q, verify_d, oe_q, oe_d, ce_q, ce_d, we_q, we_d, rd_q, rd_d, rst_q, rst_d;
  logic [31:0]           prdata_q, prdata_d;
  logic                  pready_q, pready_d, pslverr_q, pslverr_d;
  logic                  rd_n_q, rd_n_d, byte_n_q, byte_n_d;
  logic                  acc, wr, start, busy;
  logic [7:0]            st;
  logic [15:0]           mask;

  assign acc   = psel && penable && !pready_q;
  assign wr    = psel && penable && pready_q && pwrite;
  assign busy  = (state_q != S_IDLE);
  assign start = wr && (paddr == flash_host_pkg::OFF_CTRL) && pwdata[flash_host_pkg::CTRL_GO];
  assign mask  = cfg_q[flash_host_pkg::CFG_BYTE] ? flash_host_pkg::BYTE_MASK : 16'hffff;
  assign st    = {sup_f_q, rb_f_q, ref_q, asel_q, ver_q, tmo_q, done_q, busy};

  always_comb
  begin
    state_d   = state_q;
    cmd_d     = cmd_q;
    step_d    = step_q;
    cnt_d     = cnt_q;
    areg_d    = areg_q;
    wreg_d    = wreg_q;
    rreg_d    = rreg_q;
    cfg_d     = cfg_q;
    fa_d      = fa_q;
    dqo_d     = dqo_q;
    done_d    = done_q;
    tmo_d     = tmo_q;
    ver_d     = ver_q;
    asel_d    = asel_q;
    ref_d     = ref_q;
    verify_d  = verify_q;
    oe_d      = oe_q;
    ce_d      = ce_q;
    we_d      = we_q;
    rd_d      = rd_q;
    rst_d     = rst_q;
    prdata_d  = prdata_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    // apb: one wait state, answer registered
    if (acc)
    begin
      pready_d = 1'b1;
      unique case (paddr)
        flash_host_pkg::OFF_CTRL:   prdata_d = {25'd0, cmd_q, 3'd0, busy};
        flash_host_pkg::OFF_ADDR:   prdata_d = 32'(areg_q);
        flash_host_pkg::OFF_WDATA:  prdata_d = {16'h0000, wreg_q};
        flash_host_pkg::OFF_RDATA:  prdata_d = {16'h0000, rreg_q};
        flash_host_pkg::OFF_STATUS: prdata_d = {24'd0, st};
        flash_host_pkg::OFF_CFG:    prdata_d = {30'd0, cfg_q};
        default:
        begin
          prdata_d  = 32'h0000_0000;
          pslverr_d = 1'b1;
        end
      endcase
    end
    // settings are locked while a transfer runs so pins never change mid-cycle
    if (wr && !busy)
    begin
      if (paddr == flash_host_pkg::OFF_ADDR)
        areg_d = pwdata[ADDR_W-1:0];
      if (paddr == flash_host_pkg::OFF_WDATA)
        wreg_d = pwdata[15:0];
      if (paddr == flash_host_pkg::OFF_CFG)
        cfg_d = pwdata[1:0];
    end
    if (start && busy)
      ref_d = 1'b1;
    unique case (state_q)
      S_IDLE:
        if (start)
        begin
          cmd_d    = flash_host_pkg::cmd_t'(pwdata[flash_host_pkg::CTRL_CMD_LSB +: 3]);
          step_d   = 2'd0;
          cnt_d    = 32'd0;
          done_d   = 1'b0;
          tmo_d    = 1'b0;
          ver_d    = 1'b0;
          ref_d    = 1'b0;
          verify_d = 1'b0;
          unique case (pwdata[flash_host_pkg::CTRL_CMD_LSB +: 3])
            flash_host_pkg::CMD_READ:    state_d = S_RD_SETUP;
            flash_host_pkg::CMD_HWRESET: state_d = S_HW_LOW;
            flash_host_pkg::CMD_RESET, flash_host_pkg::CMD_AUTOSEL, flash_host_pkg::CMD_PROGRAM:
              if (sup_f_q)
                state_d = S_WR_SETUP;
              else
                ref_d = 1'b1;
            default: ref_d = 1'b1;
          endcase
        end
      S_WR_SETUP:
      begin
        {fa_d, dqo_d} = seq_word(cmd_q, step_q, areg_q, wreg_q);
        oe_d    = 1'b1;
        rd_d    = 1'b0;
        cnt_d   = 32'd0;
        state_d = S_WR_LOW;
      end
      S_WR_LOW:
      begin
        ce_d  = 1'b0;
        we_d  = 1'b0;
        cnt_d = cnt_q + 32'd1;
        if (cnt_q == 32'(flash_host_pkg::C_WE))
        begin
          ce_d    = 1'b1;
          we_d    = 1'b1;
          cnt_d   = 32'd0;
          state_d = S_WR_HIGH;
        end
      end
      S_WR_HIGH:
      begin
        cnt_d = cnt_q + 32'd1;
        if (cnt_q == 32'(flash_host_pkg::C_WH))
        begin
          oe_d  = 1'b0;
          cnt_d = 32'd0;
          if (step_q != last_step(cmd_q))
          begin
            step_d  = step_q + 2'd1;
            state_d = S_WR_SETUP;
          end
          else if (cmd_q == flash_host_pkg::CMD_PROGRAM)
            state_d = S_PG_WAIT;
          else
          begin
            asel_d  = (cmd_q == flash_host_pkg::CMD_AUTOSEL);
            done_d  = 1'b1;
            state_d = S_IDLE;
          end
        end
      end
      S_PG_WAIT:
      begin
        cnt_d = cnt_q + 32'd1;
        if (cnt_q >= 32'(flash_host_pkg::C_BUSY) && rb_f_q)
        begin
          verify_d = 1'b1;
          state_d  = S_RD_SETUP;
        end
        else if (cnt_q == 32'(PROG_TIMEOUT))
        begin
          tmo_d   = 1'b1;
          cmd_d   = flash_host_pkg::CMD_RESET;
          step_d  = 2'd0;
          state_d = S_WR_SETUP;
        end
      end
      S_RD_SETUP:
      begin
        fa_d    = areg_q;
        cnt_d   = 32'd0;
        state_d = S_RD_LOW;
      end
      S_RD_LOW:
      begin
        ce_d  = 1'b0;
        rd_d  = 1'b1;
        cnt_d = cnt_q + 32'd1;
        // wait for access time plus synchroniser depth, then a settled word
        if (cnt_q >= 32'(flash_host_pkg::C_RD + 3) && dq2_q == dq3_q)
        begin
          rreg_d  = dq3_q & mask;
          ce_d    = 1'b1;
          rd_d    = 1'b0;
          state_d = S_RD_END;
        end
      end
      S_RD_END:
      begin
        if (verify_q && ((rreg_q ^ wreg_q) & mask) != 16'h0000)
          ver_d = 1'b1;
        done_d  = 1'b1;
        state_d = S_IDLE;
      end
      S_HW_LOW:
      begin
        rst_d = 1'b0;
        cnt_d = cnt_q + 32'd1;
        if (cnt_q == 32'(flash_host_pkg::C_RP))
        begin
          rst_d   = 1'b1;
          cnt_d   = 32'd0;
          state_d = S_HW_REC;
        end
      end
      S_HW_REC:
      begin
        cnt_d = cnt_q + 32'd1;
        if (cnt_q == 32'(flash_host_pkg::C_RH))
        begin
          asel_d  = 1'b0;
          done_d  = 1'b1;
          state_d = S_IDLE;
        end
      end
    endcase
    // pins leave flops directly, so the active-low copies get registers of their own
    rd_n_d   = !rd_d;
    byte_n_d = !cfg_d[flash_host_pkg::CFG_BYTE];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q   <= S_IDLE;
      cmd_q     <= flash_host_pkg::CMD_READ;
      step_q    <= 2'd0;
      cnt_q     <= 32'd0;
      areg_q    <= '0;
      wreg_q    <= 16'h0000;
      rreg_q    <= 16'h0000;
      cfg_q     <= 2'b00;
      fa_q      <= '0;
      dqo_q     <= 16'h0000;
      done_q    <= 1'b0;
      tmo_q     <= 1'b0;
      ver_q     <= 1'b0;
      asel_q    <= 1'b0;
      ref_q     <= 1'b0;
      verify_q  <= 1'b0;
      oe_q      <= 1'b0;
      ce_q      <= 1'b1;
      we_q      <= 1'b1;
      rd_q      <= 1'b0;
      rst_q     <= 1'b1;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      rd_n_q    <= 1'b1;
      byte_n_q  <= 1'b1;
    end
    else
    begin
      state_q   <= state_d;
      cmd_q     <= cmd_d;
      step_q    <= step_d;
      cnt_q     <= cnt_d;
      areg_q    <= areg_d;
      wreg_q    <= wreg_d;
      rreg_q    <= rreg_d;
      cfg_q     <= cfg_d;
      fa_q      <= fa_d;
      dqo_q     <= dqo_d;
      done_q    <= done_d;
      tmo_q     <= tmo_d;
      ver_q     <= ver_d;
      asel_q    <= asel_d;
      ref_q     <= ref_d;
      verify_q  <= verify_d;
      oe_q      <= oe_d;
      ce_q      <= ce_d;
      we_q      <= we_d;
      rd_q      <= rd_d;
      rst_q     <= rst_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      rd_n_q    <= rd_n_d;
      byte_n_q  <= byte_n_d;
    end
  end

  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign fl_addr       = fa_q;
  assign fl_dq_o       = dqo_q;
  assign fl_dq_oe      = oe_q;
  assign fl_ce_n       = ce_q;
  assign fl_we_n       = we_q;
  assign fl_oe_n       = rd_n_q;
  assign fl_reset_n    = rst_q;
  assign fl_byte_n     = byte_n_q;
  assign id_voltage_en = cfg_q[flash_host_pkg::CFG_IDV];
endmodule // flash_host

// file: dv/flash_host_properties.sv
`timescale 1ns/10ps
module flash_host_properties #(
  parameter int ADDR_W = 19
) (
  // clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic              pslverr,
  // flash pins
  input wire logic [ADDR_W-1:0] fl_addr,
  input wire logic [15:0]       fl_dq_o,
  input wire logic              fl_dq_oe,
  input wire logic              fl_ce_n,
  input wire logic              fl_we_n,
  input wire logic              fl_oe_n,
  input wire logic              fl_reset_n
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========================================================
  // apb answer
  a_ready_one_wait:
    assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  a_ready_single:
    assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_err_with_ready:
    assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // ==========================================================
  // flash write cycles and hardware reset
  a_write_oe_high:
    assert property (!fl_ce_n && !fl_we_n |-> fl_oe_n)
    else $error("write strobe with output enable low");
  a_we_needs_ce:
    assert property (!fl_we_n |-> !fl_ce_n)
    else $error("write strobe without chip select");
  a_pulse_width:
    assert property ($fell(fl_we_n) |-> (!fl_we_n && !fl_ce_n)[*5])
    else $error("write pulse too short");
  a_addr_hold:
    assert property (!fl_we_n && $past(!fl_we_n) |-> $stable(fl_addr) && $stable(fl_dq_o) && fl_dq_oe)
    else $error("address or data moved inside write pulse");
  a_data_hold:
    assert property ($rose(fl_we_n) |-> (fl_dq_oe && $stable(fl_dq_o))[*3])
    else $error("data released at write strobe rise");
  a_reset_quiet:
    assert property (!fl_reset_n |-> fl_we_n && fl_ce_n)
    else $error("write during hardware reset");
  a_reset_width:
    assert property ($fell(fl_reset_n) |-> !fl_reset_n[*8])
    else $error("hardware reset pulse too short");
endmodule // flash_host_properties

bind flash_host flash_host_properties #(.ADDR_W(ADDR_W)) props_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n),
  .fl_oe_n(fl_oe_n), .fl_reset_n(fl_reset_n)
);

// file: dv/flash_dev_model.sv
`timescale 1ns/10ps
module flash_dev_model #(
  parameter logic [18:0] U1A     = 19'h0_0001,
  parameter logic [18:0] U2A     = 19'h0_0002,
  parameter logic [15:0] U1D     = 16'h0001,
  parameter logic [15:0] U2D     = 16'h0002,
  parameter logic [15:0] ASC     = 16'h0003,
  parameter logic [15:0] PGC     = 16'h0004,
  parameter logic [7:0]  PROT    = 8'h00,
  parameter logic [15:0] MFR     = 16'h0011,  // arbitrary value
  parameter logic [15:0] DEV     = 16'h0022,  // arbitrary value
  parameter int          BUSY_NS = 300
) (
  // host pins
  input  wire logic [18:0] fl_addr,
  input  wire logic [15:0] fl_dq_o,
  input  wire logic        fl_ce_n,
  input  wire logic        fl_we_n,
  input  wire logic        fl_oe_n,
  input  wire logic        fl_reset_n,
  input  wire logic        fl_byte_n,
  input  wire logic        id_voltage_en,
  input  wire logic        supply_ok,
  // answers
  output logic      [15:0] fl_dq_i,
  output logic             ready_busy_n
);
  localparam int S_RD = 0, S_U1 = 1, S_U2 = 2, S_PG = 3, S_AS = 4;
  int          st   = S_RD;
  logic        busy = 1'b0;
  logic [15:0] last = 16'hffff;
  logic [18:0] pa;
  logic [18:0] wa;
  logic [15:0] pd;
  realtime     t0;
  logic [15:0] mem [logic [18:0]];
  event        prog_ev;
  wire         wr_on    = !fl_ce_n && !fl_we_n && fl_oe_n;
  wire  [7:0]  prot_eff = PROT & ~{8{id_voltage_en}};
  function automatic logic [15:0] arr(input logic [18:0] a);
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction
  function automatic logic [15:0] rd_val(input logic [18:0] a);
    logic [7:0] off;
    off = fl_byte_n ? a[7:0] : a[7:0] >> 1;
    // no sector is ever erase-suspended here, so outside autoselect every read is array data
    if (st != S_AS)
      return arr(a);
    case (off)
      8'h00: return MFR;
      8'h01: return DEV;
      8'h02: return {15'h0000, prot_eff[a[17:15]]};
      default: return arr(a);
    endcase
  endfunction
  assign ready_busy_n = !busy;
  initial fl_dq_i = 16'hffff;
  // no pull on the data bus: a released bus shows the inverse of its last value
  always @(fl_ce_n or fl_oe_n or fl_reset_n or fl_addr or st)
    if (!fl_ce_n && !fl_oe_n && fl_reset_n)
    begin
      fl_dq_i = rd_val(fl_addr);
      last = fl_dq_i;
    end
    else
      fl_dq_i = ~last;
  always @(posedge wr_on)
  begin
    t0 = $realtime;
    wa = fl_addr;
  end
  always @(negedge wr_on)
    if (fl_reset_n && supply_ok && !busy && ($realtime - t0) >= 5.0)
    begin
      // the fourth program write is data, even when it happens to equal the reset code
      if (fl_dq_o == flash_host_pkg::RESET_CODE && st != S_PG)
        st = S_RD;
      else
        case (st)
          S_U1: st = (wa == U2A && fl_dq_o == U2D) ? S_U2 : S_RD;
          S_U2: st = wa != U1A ? S_RD : fl_dq_o == ASC ? S_AS : fl_dq_o == PGC ? S_PG : S_RD;
          S_PG:
          begin
            st = S_RD;
            if (!prot_eff[wa[17:15]])
            begin
              pa = wa;
              pd = fl_dq_o;
              busy = 1'b1;
              ->prog_ev;
            end
          end
          S_AS: st = S_AS;
          default: st = (wa == U1A && fl_dq_o == U1D) ? S_U1 : S_RD;
        endcase
    end
  always @(negedge fl_reset_n or negedge supply_ok)
  begin
    disable prog_run;
    busy = 1'b0;
    st = S_RD;
  end
  always
  begin : prog_run
    @(prog_ev);
    #(BUSY_NS);
    mem[pa] = arr(pa) & pd;
    busy = 1'b0;
  end
endmodule // flash_dev_model

// file: dv/flash_host_bench.sv
`timescale 1ns/10ps
module flash_host_bench;
  localparam logic [18:0] PSEC = 19'h1_0040;
  // unlock addresses, data and command codes shared by host and model
  localparam logic [18:0] U1A      = 19'h0_0123;
  localparam logic [18:0] U2A      = 19'h0_0234;
  localparam logic [15:0] U1D      = 16'h00c3;
  localparam logic [15:0] U2D      = 16'h003c;
  localparam logic [15:0] ASC      = 16'h0077;
  localparam logic [15:0] PGC      = 16'h0066;
  localparam logic [7:0]  PROT_MAP = 8'h04;
  localparam logic [15:0] MFR_ID   = 16'h005a;  // arbitrary value
  localparam logic [15:0] DEV_ID   = 16'h00a5;  // arbitrary value
  localparam int          PG_TMO   = 200;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        supply_ok = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [18:0] fl_addr;
  logic [15:0] fl_dq_o;
  logic [15:0] fl_dq_i;
  logic        fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n, fl_reset_n, fl_byte_n, id_voltage_en, ready_busy_n;
  int          num_errors = 0;
  int          n_checks = 0;
  int          cycles = 0;
  logic [31:0] lfsr = 32'h0000_0020;
  logic [15:0] shadow [logic [18:0]];
  logic [31:0] r, st;
  logic        e;
  logic [18:0] a;
  logic [18:0] as_addr [4] = '{19'h0_0000, 19'h0_0001, 19'h1_0002, 19'h0_0002};
  logic [15:0] as_exp [4] = '{MFR_ID, DEV_ID, 16'h0001, 16'h0000};
  always #5 pclk = ~pclk;
  flash_host #(.PROG_TIMEOUT(PG_TMO), .UNLOCK1_ADDR(U1A), .UNLOCK2_ADDR(U2A), .UNLOCK1_DATA(U1D),
    .UNLOCK2_DATA(U2D), .AUTOSEL_CODE(ASC), .PROGRAM_CODE(PGC)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o),
    .fl_dq_i(fl_dq_i), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n),
    .fl_reset_n(fl_reset_n), .fl_byte_n(fl_byte_n), .id_voltage_en(id_voltage_en), .ready_busy_n(ready_busy_n),
    .supply_ok(supply_ok));
  flash_dev_model #(.U1A(U1A), .U2A(U2A), .U1D(U1D), .U2D(U2D), .ASC(ASC),
    .PGC(PGC), .PROT(PROT_MAP), .MFR(MFR_ID), .DEV(DEV_ID)) dev_u (
    .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n),
    .fl_reset_n(fl_reset_n), .fl_byte_n(fl_byte_n), .id_voltage_en(id_voltage_en), .supply_ok(supply_ok),
    .fl_dq_i(fl_dq_i), .ready_busy_n(ready_busy_n));
  // ==========================================================
  // expectations
  function automatic logic [31:0] f_lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [15:0] f_mem(input logic [18:0] x);
    return shadow.exists(x) ? shadow[x] : 16'hffff;
  endfunction
  // ==========================================================
  // bus tasks and comparisons
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    check_data({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask
  // request held until pready is sampled high, then released on that same edge
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input flash_host_pkg::cmd_t c);
    apb(1'b1, flash_host_pkg::OFF_CTRL, {25'h000_0000, c, 4'h1});
    do apb(1'b0, flash_host_pkg::OFF_STATUS, 32'h0000_0000); while (r[flash_host_pkg::ST_BUSY] !== 1'b0);
    st = r;
  endtask
  task automatic prog(input logic [18:0] x, input logic [15:0] d);
    apb(1'b1, flash_host_pkg::OFF_ADDR, {13'h0000, x});
    apb(1'b1, flash_host_pkg::OFF_WDATA, {16'h0000, d});
    run(flash_host_pkg::CMD_PROGRAM);
  endtask
  task automatic read_at(input logic [18:0] x);
    apb(1'b1, flash_host_pkg::OFF_ADDR, {13'h0000, x});
    run(flash_host_pkg::CMD_READ);
    apb(1'b0, flash_host_pkg::OFF_RDATA, 32'h0000_0000);
  endtask
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      num_errors++;
      print_verdict();
    end
  end
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, flash_host_pkg::OFF_CFG, 32'h0000_0000);
    check_data(r, 32'h0000_0000);
    apb(1'b0, 8'h18, 32'h0000_0000);
    check_bit(e, 1'b1);
    repeat (10) @(posedge pclk);
    for (int i = 0; i < 8; i++)
    begin
      // a bare seed of 32 needs many steps before its high bits carry anything
      repeat (24)
        lfsr = f_lfsr(lfsr);
      a = 19'h0_0100 + {16'h0000, lfsr[2:0]};
      prog(a, lfsr[31:16]);
      check_bit(st[flash_host_pkg::ST_VERIFY], (f_mem(a) & lfsr[31:16]) != lfsr[31:16]);
      check_bit(st[flash_host_pkg::ST_TIMEOUT], 1'b0);
      check_bit(st[flash_host_pkg::ST_RDY], 1'b1);
      shadow[a] = f_mem(a) & lfsr[31:16];
      read_at(a);
      check_data(r, {16'h0000, f_mem(a)});
    end
    prog(PSEC, 16'h1234);
    check_bit(st[flash_host_pkg::ST_VERIFY], 1'b1);
    apb(1'b1, flash_host_pkg::OFF_CFG, 32'h0000_0002);
    prog(PSEC, 16'h1234);
    check_bit(st[flash_host_pkg::ST_VERIFY], 1'b0);
    apb(1'b1, flash_host_pkg::OFF_CFG, 32'h0000_0000);
    run(flash_host_pkg::CMD_AUTOSEL);
    check_bit(st[flash_host_pkg::ST_AUTOSEL], 1'b1);
    check_bit(st[flash_host_pkg::ST_DONE], 1'b1);
    for (int k = 0; k < 16; k++)
    begin
      apb(1'b1, flash_host_pkg::OFF_CFG, {31'h0000_0000, k[3]});
      read_at({as_addr[k % 4][18:8], as_addr[k % 4][7:0] << k[3]});
      check_data(r & 32'h0000_00ff, {16'h0000, as_exp[k % 4]});
    end
    apb(1'b1, flash_host_pkg::OFF_CFG, 32'h0000_0000);
    run(flash_host_pkg::CMD_RESET);
    check_bit(st[flash_host_pkg::ST_AUTOSEL], 1'b0);
    read_at(a);
    check_data(r, {16'h0000, f_mem(a)});
    run(flash_host_pkg::CMD_AUTOSEL);
    run(flash_host_pkg::CMD_HWRESET);
    check_bit(st[flash_host_pkg::ST_AUTOSEL], 1'b0);
    read_at(PSEC);
    check_data(r, 32'h0000_1234);
    supply_ok <= 1'b0;
    repeat (10) @(posedge pclk);
    prog(a, 16'h0000);
    check_bit(st[flash_host_pkg::ST_REFUSED], 1'b1);
    check_bit(st[flash_host_pkg::ST_SUPPLY], 1'b0);
    supply_ok <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(1'b1, flash_host_pkg::OFF_CTRL, {25'h000_0000, flash_host_pkg::CMD_PROGRAM, 4'h1});
    run(flash_host_pkg::CMD_PROGRAM);
    check_bit(st[flash_host_pkg::ST_REFUSED], 1'b1);
    read_at(a);
    check_data(r, 32'h0000_0000);
    print_verdict();
  end
endmodule // flash_host_bench
